// ---- logic/adctrc_pkg.sv ----
/*
  adctrc_pkg: register offsets, field positions, reset values, trigger
  codes and timing counts of the converter trigger and result control.
  Assumes an 8-bit processor register port with I/O and data-space views.
*/
package adctrc_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_RESULT_LOW = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h05;
  localparam logic [7:0] OFS_CONTROL_A = 8'h06;
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h07;
  localparam logic [7:0] OFS_TRIGGER_SOURCE = 8'h8E;
  localparam logic [7:0] DATA_SPACE_SHIFT = 8'h20;
  localparam logic [7:0] LOW_IO_LIMIT = 8'h40;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO_TRIG = 5;
  localparam int BIT_DONE_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_LEFT_ALIGN = 5;
  localparam int DIFF_SEL_LO = 8;
  localparam int DIFF_SEL_HI = 29;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [2:0] RST_TRIGGER_SOURCE = 3'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;
  // ************************************************************
  // trigger sources and timing counts
  // ************************************************************
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam int FIRST_CONV_CLOCKS = 25;
  localparam int NORMAL_CONV_CLOCKS = 13;
  typedef enum logic [2:0] {
    ADCTRC_IDLE = 3'b001,
    ADCTRC_CONV = 3'b010,
    ADCTRC_DONE = 3'b100
  } adctrc_state_t;
endpackage

// ---- logic/adctrc_prescaler.sv ----
/*
  adctrc_prescaler: divides the system clock into a one-cycle converter
  clock tick chosen by a three-bit code.
  Assumes one clock domain; runs only while enabled.
*/
`timescale 1ns/100ps
module adctrc_prescaler import adctrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // control
  input wire logic run,
  input wire logic [2:0] code,
  // tick out
  output logic tick
);
  logic [6:0] count_r;
  logic [6:0] limit;

  // ************************************************************
  // divisor from code
  // ************************************************************
  always_comb begin
    if (code == 3'h0) begin
      limit = 7'h01;
    end else begin
      limit = 7'((8'h01 << code) - 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= 7'h00;
    end else if (clk_en) begin
      if (!run || count_r >= limit) begin
        count_r <= 7'h00;
      end else begin
        count_r <= count_r + 7'h01;
      end
    end
  end

  assign tick = clk_en && run && (count_r == limit);
endmodule

// ---- logic/adctrc_top.sv ----
/*
  adctrc_top: trigger, conversion timing, completion flag and result
  register logic of a 10-bit converter behind an 8-bit register port.
  Assumes the analog core samples on conv_start and supplies its result
  in conv_data by the end of the timed conversion; trigger flags come
  from logic on the same clock.
*/
// What this block does
// - auto trigger starts on selected source's rising edge
// - flag sets when result registers load
// - interrupt needs flag, enable, global enable
// - vector execution clears the flag
// - write one clears flag, zero keeps
// - prescaler codes divide by two to 128
// - differential results are two's complement
// - low-byte read locks result until high read
// - right aligned: low bits7..0, high bits9..8
// - left aligned: high bits9..2, low top two
// - trigger source ignored without auto trigger
// - source switch onto set flag is edge
// - choosing free running makes no trigger
// - trigger code table of eight sources
// - low registers seen at offset and plus 0x20
// - enable powers; disable aborts conversion
// - start bit starts; 25 then 13 clocks
// - start reads one while busy; zero ignored
`timescale 1ns/100ps
module adctrc_top import adctrc_pkg::*; #(
  parameter int RESULT_W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_data_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // interrupt
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic irq_req,
  // trigger flags, index by source code
  input wire logic [7:1] trigger_flags,
  // analog core
  output logic converter_power,
  output logic conv_start,
  output logic [4:0] input_channel,
  input wire logic [RESULT_W-1:0] conv_data
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic converter_enable_r;
  logic auto_trigger_enable_r;
  logic conversion_complete_flag_r;
  logic conversion_irq_enable_r;
  logic [2:0] converter_clock_divider_r;
  logic [7:0] input_select_register_r;
  logic [2:0] trigger_source_select_r;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] captured_r;
  logic locked_r;
  logic initialised_r;
  logic trig_level_r;
  logic start_pending_r;
  logic [4:0] clocks_left_r;
  adctrc_state_t state_r;
  logic [7:0] reg_rdata_r;
  logic [7:0] rd_value;
  logic [7:0] local_addr;
  logic mapped;
  logic wr_ctl_a;
  logic wr_sel;
  logic wr_trig;
  logic rd_low;
  logic rd_high;
  logic trig_level;
  logic trig_event;
  logic sw_start;
  logic conv_tick;
  logic busy;
  logic finish;
  logic load_result;

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic [7:0] to_local(input logic [7:0] a,
                                          input logic ds);
    logic [7:0] r;
    r = a;
    if (ds && a >= DATA_SPACE_SHIFT
        && a < 8'(DATA_SPACE_SHIFT + LOW_IO_LIMIT)) begin
      r = 8'(a - DATA_SPACE_SHIFT);
    end else if (ds && a < DATA_SPACE_SHIFT) begin
      r = 8'hFF;
    end else if (!ds && a >= LOW_IO_LIMIT) begin
      r = 8'hFF;
    end
    return r;
  endfunction

  assign local_addr = to_local(reg_addr, reg_data_space);
  assign mapped = (local_addr == OFS_RESULT_LOW)
    || (local_addr == OFS_RESULT_HIGH) || (local_addr == OFS_CONTROL_A)
    || (local_addr == OFS_INPUT_SELECT)
    || (reg_data_space && reg_addr == OFS_TRIGGER_SOURCE);
  assign reg_hit = mapped && (reg_wr || reg_rd);
  assign wr_ctl_a = clk_en && reg_wr && local_addr == OFS_CONTROL_A;
  assign wr_sel = clk_en && reg_wr && local_addr == OFS_INPUT_SELECT;
  assign wr_trig = clk_en && reg_wr && reg_data_space
    && reg_addr == OFS_TRIGGER_SOURCE;
  assign rd_low = clk_en && reg_rd && local_addr == OFS_RESULT_LOW;
  assign rd_high = clk_en && reg_rd && local_addr == OFS_RESULT_HIGH;

  // ************************************************************
  // trigger selection
  // ************************************************************
  always_comb begin
    if (trigger_source_select_r == TRIG_FREE_RUN) begin
      trig_level = conversion_complete_flag_r;
    end else begin
      trig_level = trigger_flags[trigger_source_select_r];
    end
  end

  // level history follows the live selection so a source switch onto a
  // set flag is an edge, and free running edges come only from the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_level_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_trig && reg_wdata[2:0] == TRIG_FREE_RUN) begin
        trig_level_r <= 1'b1;
      end else begin
        trig_level_r <= trig_level;
      end
    end
  end

  assign trig_event = auto_trigger_enable_r && converter_enable_r
    && trig_level && !trig_level_r;
  assign sw_start = wr_ctl_a && reg_wdata[BIT_START]
    && (reg_wdata[BIT_ENABLE]);

  // ************************************************************
  // control register a and selection registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_enable_r <= RST_CONTROL_A[BIT_ENABLE];
      auto_trigger_enable_r <= RST_CONTROL_A[BIT_AUTO_TRIG];
      conversion_irq_enable_r <= RST_CONTROL_A[BIT_IRQ_EN];
      converter_clock_divider_r <= RST_CONTROL_A[2:0];
      input_select_register_r <= RST_INPUT_SELECT;
      trigger_source_select_r <= RST_TRIGGER_SOURCE;
    end else if (clk_en) begin
      if (wr_ctl_a) begin
        converter_enable_r <= reg_wdata[BIT_ENABLE];
        auto_trigger_enable_r <= reg_wdata[BIT_AUTO_TRIG];
        conversion_irq_enable_r <= reg_wdata[BIT_IRQ_EN];
        converter_clock_divider_r <= reg_wdata[2:0];
      end
      if (wr_sel) begin
        input_select_register_r <= reg_wdata;
      end
      if (wr_trig) begin
        trigger_source_select_r <= reg_wdata[2:0];
      end
    end
  end

  // ************************************************************
  // completion flag
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      conversion_complete_flag_r <= RST_CONTROL_A[BIT_DONE_FLAG];
    end else if (clk_en) begin
      if (load_result) begin
        conversion_complete_flag_r <= 1'b1;
      end else if (irq_vector_ack) begin
        conversion_complete_flag_r <= 1'b0;
      end else if (wr_ctl_a && reg_wdata[BIT_DONE_FLAG]) begin
        conversion_complete_flag_r <= 1'b0;
      end
    end
  end

  assign irq_req = conversion_complete_flag_r && conversion_irq_enable_r
    && global_irq_enable;

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  adctrc_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .run(converter_enable_r),
    .code(converter_clock_divider_r),
    .tick(conv_tick)
  );

  assign busy = (state_r != ADCTRC_IDLE) || start_pending_r;
  assign finish = (state_r == ADCTRC_CONV) && conv_tick
    && clocks_left_r == 5'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ADCTRC_IDLE;
      start_pending_r <= 1'b0;
      clocks_left_r <= 5'h00;
      initialised_r <= 1'b0;
      captured_r <= RST_RESULT;
    end else if (clk_en) begin
      if (!converter_enable_r || (wr_ctl_a && !reg_wdata[BIT_ENABLE])) begin
        state_r <= ADCTRC_IDLE;
        start_pending_r <= 1'b0;
        initialised_r <= 1'b0;
        if (sw_start) begin
          start_pending_r <= 1'b1;
        end
      end else begin
        unique case (state_r)
          ADCTRC_IDLE: begin
            if (start_pending_r || sw_start || trig_event) begin
              start_pending_r <= 1'b0;
              state_r <= ADCTRC_CONV;
              clocks_left_r <= initialised_r
                ? 5'(NORMAL_CONV_CLOCKS)
                : 5'(FIRST_CONV_CLOCKS);
            end
          end
          ADCTRC_CONV: begin
            if (conv_tick) begin
              clocks_left_r <= clocks_left_r - 5'h01;
            end
            if (finish) begin
              captured_r <= conv_data;
              initialised_r <= 1'b1;
              state_r <= ADCTRC_DONE;
            end
          end
          ADCTRC_DONE: begin
            state_r <= ADCTRC_IDLE;
          end
        endcase
      end
    end
  end

  assign conv_start = clk_en && converter_enable_r
    && state_r == ADCTRC_IDLE
    && (start_pending_r || sw_start || trig_event);
  assign load_result = state_r == ADCTRC_DONE && converter_enable_r;

  // ************************************************************
  // result register and read lock
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      result_r <= RST_RESULT;
      locked_r <= 1'b0;
    end else if (clk_en) begin
      if (rd_low) begin
        locked_r <= 1'b1;
      end else if (rd_high) begin
        locked_r <= 1'b0;
      end
      if (load_result && !locked_r) begin
        result_r <= captured_r;
      end
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  function automatic logic [7:0] result_byte(input logic [9:0] v,
                                             input logic left,
                                             input logic high);
    logic [7:0] b;
    if (left) begin
      b = high ? v[9:2] : {v[1:0], 6'h00};
    end else begin
      b = high ? {6'h00, v[9:8]} : v[7:0];
    end
    return b;
  endfunction

  always_comb begin
    rd_value = 8'h00;
    if (local_addr == OFS_RESULT_LOW) begin
      rd_value = result_byte(result_r,
        input_select_register_r[BIT_LEFT_ALIGN], 1'b0);
    end else if (local_addr == OFS_RESULT_HIGH) begin
      rd_value = result_byte(result_r,
        input_select_register_r[BIT_LEFT_ALIGN], 1'b1);
    end else if (local_addr == OFS_CONTROL_A) begin
      rd_value = {converter_enable_r, busy, auto_trigger_enable_r,
        conversion_complete_flag_r, conversion_irq_enable_r,
        converter_clock_divider_r};
    end else if (local_addr == OFS_INPUT_SELECT) begin
      rd_value = input_select_register_r;
    end else if (reg_data_space && reg_addr == OFS_TRIGGER_SOURCE) begin
      rd_value = {5'h00, trigger_source_select_r};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata_r <= rd_value;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign converter_power = converter_enable_r;
  assign input_channel = input_select_register_r[4:0];
endmodule

// ---- testbench/adctrc_assertions.sv ----
/*
  adctrc_assertions: port checker of adctrc_top.
  Assumes only the top's ports; bound to every adctrc_top below.
*/
`timescale 1ns/100ps
module adctrc_assertions import adctrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_data_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  // interrupt and core
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic irq_req,
  input wire logic converter_power,
  input wire logic conv_start
);
  // ****************************************
  // decode helpers
  // ****************************************
  logic [7:0] io_a;
  logic mapped;
  logic ctl_wr;
  logic en_bit;
  assign io_a = reg_addr - (reg_data_space ? DATA_SPACE_SHIFT : 8'h00);
  assign mapped = (io_a >= OFS_RESULT_LOW && io_a <= OFS_INPUT_SELECT) ||
    (reg_data_space && reg_addr == OFS_TRIGGER_SOURCE);
  assign ctl_wr = reg_wr && clk_en && io_a == OFS_CONTROL_A;
  assign en_bit = reg_wdata[BIT_ENABLE];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // properties
  // ****************************************
  sequence s_cold_start;
    conv_start && $rose(converter_power);
  endsequence
  sequence s_early_irq;
    ##[1:49] $rose(irq_req);
  endsequence
  a_hit_decode: assert property (
    (reg_rd || reg_wr) |-> reg_hit == mapped)
    else $error("register hit decode wrong");
  a_unmapped_zero: assert property (
    reg_rd && clk_en && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_power_follows: assert property (
    ctl_wr |=> converter_power == $past(en_bit))
    else $error("power does not follow enable");
  a_start_powered: assert property (
    conv_start |-> converter_power || (ctl_wr && en_bit))
    else $error("start while switched off");
  a_start_pulse: assert property (
    conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_vector_clears: assert property (
    irq_vector_ack && clk_en |=> !irq_req)
    else $error("vector entry left request");
  a_irq_global: assert property (
    !global_irq_enable |-> !irq_req)
    else $error("request without global enable");
  a_first_latency: assert property (
    s_cold_start |-> not s_early_irq)
    else $error("first conversion too short");
endmodule
bind adctrc_top adctrc_assertions u_adctrc_assertions (.clk, .rst,
  .clk_en, .reg_addr, .reg_data_space, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .reg_hit, .global_irq_enable, .irq_vector_ack, .irq_req,
  .converter_power, .conv_start);

// ---- testbench/adctrc_core_model.sv ----
/*
  adctrc_core_model: analog sampling core beside adctrc_top.
  Assumes the bench sets sample_val before each conversion starts.
*/
`timescale 1ns/100ps
module adctrc_core_model (
  // clock
  input wire logic clk,
  // from the block
  input wire logic converter_power,
  input wire logic conv_start,
  // from the bench
  input wire logic [9:0] sample_val,
  // to the block
  output logic [9:0] conv_data
);
  logic [9:0] held_r;
  // samples at start; differential values already two's complement
  always_ff @(posedge clk) begin
    if (conv_start) begin
      held_r <= sample_val;
    end
  end
  // switched off: inverse shown, never the old value
  assign conv_data = converter_power ? held_r : ~held_r;
endmodule

// ---- testbench/adc_trigger_result_control_test.sv ----
/*
  adc_trigger_result_control_test: self-checking bench of adctrc_top.
  Assumes adctrc_core_model and the bound port checker.
*/
`timescale 1ns/100ps
module adc_trigger_result_control_test import adctrc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_data_space = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_hit, irq_req, converter_power, conv_start;
  logic global_irq_enable = 1'b1;
  logic irq_vector_ack = 1'b0;
  logic [7:1] trigger_flags = 7'h00;
  logic [4:0] input_channel;
  logic [9:0] conv_data;
  logic [9:0] sample_val = 10'h000;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [9:0] v;
  int num_errors = 0;
  int checks = 0;
  int starts = 0;
  int cycles = 0;
  int seed = 32'h2802;
  int n, k, s0;
  always #10 clk = ~clk;
  adctrc_top u_adctrc_top (.clk, .rst, .clk_en, .reg_addr,
    .reg_data_space, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit,
    .global_irq_enable, .irq_vector_ack, .irq_req, .trigger_flags,
    .converter_power, .conv_start, .input_channel, .conv_data);
  adctrc_core_model u_adctrc_core_model (.clk, .converter_power,
    .conv_start, .sample_val, .conv_data);
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_data_space, reg_addr} = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(negedge clk);
    {reg_data_space, reg_addr} = a;
    exp_q.push_back(e);
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    while (irq_req !== 1'b1 && c < 20000) begin
      @(negedge clk);
      c++;
    end
    chk({7'h00, irq_req}, 8'h01);
  endtask
  task automatic win(input int c, input int t, input int kd);
    int dv;
    dv = (kd < 2) ? 2 : (1 << kd);
    chk({7'h00, (c >= t * dv - dv - 2) && (c <= t * dv + dv + 2)}, 8'h01);
  endtask
  task automatic end_of_test();
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (conv_start === 1'b1) begin
      starts++;
    end
    if (rd_d && exp_q.size() > 0) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    rd_d <= reg_rd;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (k = 4; k < 8; k++) begin
      rd(9'(k), 8'h00);
      rd(9'h120 + 9'(k), 8'h00);
    end
    rd(9'h18E, 8'h00);
    rd(9'h08E, 8'h00);
    v = 10'($random(seed));
    wr(9'h18E, v[7:0]);
    rd(9'h18E, v[7:0] & 8'h07);
    wr(9'h006, 8'h80);
    s0 = starts;
    trigger_flags = 7'($random(seed));
    @(negedge clk);
    trigger_flags = ~trigger_flags;
    repeat (4) @(negedge clk);
    trigger_flags = 7'h00;
    chk(8'(starts - s0), 8'h00);
    $display("map and reset test done");
    for (k = 0; k < 8; k++) begin
      wr(9'h006, 8'h10);
      wr(9'h006, 8'hC8 | 8'(k));
      wait_irq(n);
      win(n, 25, k);
      wr(9'h006, 8'hD8 | 8'(k));
      wait_irq(n);
      win(n, 13, k);
    end
    $display("divider test done");
    wr(9'h006, 8'h10);
    sample_val = v;
    wr(9'h127, 8'h10);
    chk({3'h0, input_channel}, 8'h10);
    wr(9'h006, 8'hC8);
    rd(9'h006, 8'hC8);
    wr(9'h006, 8'h88);
    rd(9'h006, 8'hC8);
    wait_irq(n);
    wr(9'h006, 8'h88);
    rd(9'h006, 8'h98);
    clk_en = 1'b0;
    wr(9'h006, 8'h10);
    clk_en = 1'b1;
    rd(9'h006, 8'h98);
    rd(9'h004, v[7:0]);
    rd(9'h005, {6'h00, v[9:8]});
    wr(9'h007, 8'h30);
    rd(9'h004, {v[1:0], 6'h00});
    rd(9'h005, v[9:2]);
    sample_val = ~v;
    for (k = 0; k < 2; k++) begin
      rd(9'h004, {v[1:0], 6'h00});
      wr(9'h006, 8'hD8);
      wait_irq(n);
      rd(9'h005, v[9:2]);
    end
    wr(9'h006, 8'hD8);
    wait_irq(n);
    rd(9'h005, ~v[9:2]);
    global_irq_enable = 1'b0;
    @(negedge clk);
    chk({7'h00, irq_req}, 8'h00);
    global_irq_enable = 1'b1;
    irq_vector_ack = 1'b1;
    @(negedge clk);
    irq_vector_ack = 1'b0;
    rd(9'h006, 8'h88);
    $display("result test done");
    for (k = 1; k < 8; k++) begin
      wr(9'h18E, 8'(k));
      wr(9'h006, 8'hB8);
      s0 = starts;
      trigger_flags = 7'($random(seed)) & ~(7'h01 << (k - 1));
      repeat (2) @(negedge clk);
      trigger_flags[k] = 1'b1;
      repeat (2) @(negedge clk);
      chk(8'(starts - s0), 8'h01);
      wait_irq(n);
      trigger_flags = 7'h00;
    end
    trigger_flags = 7'h04;
    wr(9'h18E, 8'h02);
    s0 = starts;
    wr(9'h18E, 8'h03);
    @(negedge clk);
    chk(8'(starts - s0), 8'h01);
    wait_irq(n);
    trigger_flags = 7'h00;
    wr(9'h18E, 8'h00);
    s0 = starts;
    repeat (40) @(negedge clk);
    chk(8'(starts - s0), 8'h00);
    wr(9'h006, 8'hF8);
    wait_irq(n);
    repeat (3) @(negedge clk);
    chk(8'(starts - s0), 8'h02);
    wr(9'h006, 8'h18);
    repeat (60) @(negedge clk);
    rd(9'h006, 8'h08);
    repeat (3) @(negedge clk);
    $display("trigger test done");
    end_of_test();
  end
endmodule
